// File: rtl/ite_pkg.sv
// Shared constants, carriers and states of the interrupt-triggered transfer engine
package ite_pkg;
  // Register word indices on the Avalon-MM slave (byte address is four times this)
  localparam logic [2:0] REG_EN0 = 3'h0;
  localparam logic [2:0] REG_EN3 = 3'h3;
  localparam logic [2:0] REG_BASE_PAGE = 3'h4;
  localparam logic [2:0] REG_STATUS = 3'h5;
  // Status fields
  localparam int ST_BUSY = 0;
  localparam int ST_ERR = 1;
  localparam int ST_SRC_LSB = 8;
  // Reset values
  localparam logic [7:0] EN_RST = 8'h00;
  localparam logic [7:0] BASE_RST = 8'h00;
  // Descriptor control byte fields
  localparam int CTL_WIDE = 0;
  localparam int CTL_RPT = 1;
  localparam int CTL_RPT_DST = 2;
  localparam int CTL_SRC_INC = 3;
  localparam int CTL_DST_INC = 4;
  localparam int CTL_RPT_IRQ = 5;
  // Byte offsets inside an eight-byte descriptor
  localparam logic [7:0] DESC_CNT = 8'h02;
  localparam logic [7:0] DESC_SRC = 8'h04;
  localparam logic [7:0] DESC_DST = 8'h06;
  // Address space
  localparam logic [3:0] TOP_NIBBLE = 4'hF;
  localparam logic [19:0] GPR_LO = 20'hFFEE0;
  localparam logic [19:0] GPR_HI = 20'hFFEFF;
  localparam logic [8:0] FULL_BLOCK = 9'h100;

  typedef struct packed {
    logic [19:0] addr;
    logic we;
    logic wide;
    logic [15:0] wdata;
  } ite_mem_req_t;

  typedef enum {
    ITE_IDLE, ITE_VEC, ITE_D0, ITE_D1, ITE_D2, ITE_D3, ITE_CHK, ITE_RD, ITE_WR,
    ITE_WB0, ITE_WB1, ITE_WB2
  } ite_state_t;
endpackage

// File: rtl/ite_engine.sv
// Interrupt-triggered transfer engine: activation, descriptor fetch, moves, bus arbitration
//
// The implementer's own choices: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module ite_engine #(
  parameter int SRC_NUM = 32,
  parameter logic [19:0] MIRROR_LO = 20'hF2000,
  parameter logic [19:0] MIRROR_HI = 20'hFEEFF
) (
  input wire logic clk,
  input wire logic reset,
  // Avalon-MM register slave
  input wire logic [2:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Activation sources and forwarded interrupts
  input wire logic [SRC_NUM-1:0] src_irq,
  output logic [SRC_NUM-1:0] cpu_irq,
  // Shared bus arbitration
  input wire logic cpu_bus_req,
  output logic cpu_bus_grant,
  // Memory master port
  output ite_pkg::ite_mem_req_t mem_req,
  output logic mem_valid,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata
);
  ite_pkg::ite_state_t state_r;
  ite_pkg::ite_mem_req_t mem_req_r;
  logic mem_valid_r;
  logic [SRC_NUM-1:0] en_r;
  logic [SRC_NUM-1:0] pend_r;
  logic [SRC_NUM-1:0] cpu_irq_r;
  logic [SRC_NUM-1:0] hw_clr;
  logic [7:0] base_r;
  logic err_r;
  logic err_set;
  logic [4:0] src_r;
  logic [7:0] vec_r;
  logic [7:0] ctl_r;
  logic [7:0] blk_r;
  logic [7:0] cnt_r;
  logic [7:0] rld_r;
  logic [15:0] sar_r;
  logic [15:0] dar_r;
  logic [8:0] left_r;
  logic last_r;
  logic [31:0] avs_readdata_r;
  logic avs_waitrequest_r;
  logic cpu_bus_grant_r;
  logic [SRC_NUM-1:0] ready;
  logic [4:0] sel;
  logic sw_wr;
  logic [15:0] step;
  logic sinc;
  logic dinc;
  logic [15:0] span;
  logic [15:0] sar_nxt;
  logic [15:0] dar_nxt;
  logic [7:0] cnt_nxt;
  logic [19:0] src_a;
  logic [19:0] dst_a;
  logic src_bad;
  logic dst_bad;
  logic done;

  assign avs_readdata = avs_readdata_r;
  assign avs_waitrequest = avs_waitrequest_r;
  assign cpu_irq = cpu_irq_r;
  assign cpu_bus_grant = cpu_bus_grant_r;
  assign mem_req = mem_req_r;
  assign mem_valid = mem_valid_r;

  assign ready = pend_r & en_r;
  always_comb begin
    sel = 5'h00;
    for (int i = SRC_NUM - 1; i >= 0; i--) begin
      if (ready[i]) begin
        sel = 5'(i);
      end
    end
  end

  // Register slave: one wait cycle, then a one-cycle answer
  assign sw_wr = avs_write && !avs_waitrequest_r;
  always_ff @(posedge clk) begin
    if (reset) begin
      avs_waitrequest_r <= 1'b1;
      avs_readdata_r <= 32'h00000000;
    end else if ((avs_read || avs_write) && avs_waitrequest_r) begin
      avs_waitrequest_r <= 1'b0;
      avs_readdata_r <= 32'h00000000;
      if (avs_read) begin
        if (avs_address <= ite_pkg::REG_EN3) begin
          avs_readdata_r[7:0] <= en_r[avs_address[1:0]*8 +: 8];
        end else if (avs_address == ite_pkg::REG_BASE_PAGE) begin
          avs_readdata_r[7:0] <= base_r;
        end else if (avs_address == ite_pkg::REG_STATUS) begin
          avs_readdata_r[ite_pkg::ST_BUSY] <= (state_r != ite_pkg::ITE_IDLE);
          avs_readdata_r[ite_pkg::ST_ERR] <= err_r;
          avs_readdata_r[ite_pkg::ST_SRC_LSB +: 5] <= src_r;
        end
      end
    end else begin
      avs_waitrequest_r <= 1'b1;
    end
  end

  // Enable bits: software write of a byte wins over the engine's own clear
  always_ff @(posedge clk) begin
    if (reset) begin
      en_r <= {SRC_NUM{1'b0}};
    end else begin
      for (int i = 0; i < SRC_NUM / 8; i++) begin
        if (sw_wr && avs_byteenable[0] && avs_address == 3'(i)) begin
          en_r[i*8 +: 8] <= avs_writedata[7:0];
        end else begin
          en_r[i*8 +: 8] <= en_r[i*8 +: 8] & ~hw_clr[i*8 +: 8];
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      base_r <= ite_pkg::BASE_RST;
    end else if (sw_wr && avs_byteenable[0] && avs_address == ite_pkg::REG_BASE_PAGE) begin
      base_r <= avs_writedata[7:0];
    end
  end

  // Error flag: set wins over the write-one clear
  always_ff @(posedge clk) begin
    if (reset) begin
      err_r <= 1'b0;
    end else if (err_set) begin
      err_r <= 1'b1;
    end else if (sw_wr && avs_byteenable[0] && avs_address == ite_pkg::REG_STATUS &&
                 avs_writedata[ite_pkg::ST_ERR]) begin
      err_r <= 1'b0;
    end
  end

  // Pending requests: a new event beats the clear of the one being taken
  always_ff @(posedge clk) begin
    if (reset) begin
      pend_r <= {SRC_NUM{1'b0}};
    end else begin
      for (int i = 0; i < SRC_NUM; i++) begin
        if (src_irq[i] && en_r[i]) begin
          pend_r[i] <= 1'b1;
        end else if (!en_r[i]) begin
          pend_r[i] <= 1'b0;
        end else if (state_r == ite_pkg::ITE_IDLE && ready != '0 && sel == 5'(i)) begin
          pend_r[i] <= 1'b0;
        end
      end
    end
  end

  // Engine owns the bus while busy or about to start
  always_ff @(posedge clk) begin
    if (reset) begin
      cpu_bus_grant_r <= 1'b0;
    end else begin
      cpu_bus_grant_r <= cpu_bus_req && state_r == ite_pkg::ITE_IDLE && ready == '0;
    end
  end

  // Transfer datapath helpers
  assign step = ctl_r[ite_pkg::CTL_WIDE] ? 16'h0002 : 16'h0001;
  assign sinc = ctl_r[ite_pkg::CTL_RPT] ? (!ctl_r[ite_pkg::CTL_RPT_DST] ||
                ctl_r[ite_pkg::CTL_SRC_INC]) : ctl_r[ite_pkg::CTL_SRC_INC];
  assign dinc = ctl_r[ite_pkg::CTL_RPT] ? (ctl_r[ite_pkg::CTL_RPT_DST] ||
                ctl_r[ite_pkg::CTL_DST_INC]) : ctl_r[ite_pkg::CTL_DST_INC];
  assign span = 16'(rld_r * blk_r) << ctl_r[ite_pkg::CTL_WIDE];
  assign src_a = {ite_pkg::TOP_NIBBLE, sar_r};
  assign dst_a = {ite_pkg::TOP_NIBBLE, dar_r};
  assign src_bad = src_a >= ite_pkg::GPR_LO && src_a <= ite_pkg::GPR_HI;
  assign dst_bad = (dst_a >= ite_pkg::GPR_LO && dst_a <= ite_pkg::GPR_HI) ||
                   (dst_a >= MIRROR_LO && dst_a <= MIRROR_HI);
  assign err_set = state_r == ite_pkg::ITE_CHK && (src_bad || dst_bad);
  assign done = state_r == ite_pkg::ITE_WB2 && mem_ack;

  always_comb begin
    sar_nxt = sinc ? sar_r + step : sar_r;
    dar_nxt = dinc ? dar_r + step : dar_r;
    cnt_nxt = cnt_r - 8'h01;
    if (last_r && ctl_r[ite_pkg::CTL_RPT]) begin
      cnt_nxt = rld_r;
      if (ctl_r[ite_pkg::CTL_RPT_DST]) begin
        dar_nxt = dar_nxt - span;
      end else begin
        sar_nxt = sar_nxt - span;
      end
    end
  end

  // Completion: forward the source interrupt and stop the descriptor
  always_comb begin
    hw_clr = '0;
    if (done && last_r && (!ctl_r[ite_pkg::CTL_RPT] || ctl_r[ite_pkg::CTL_RPT_IRQ])) begin
      hw_clr[src_r] = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      cpu_irq_r <= {SRC_NUM{1'b0}};
    end else begin
      cpu_irq_r <= hw_clr;
    end
  end

  // Main sequencer: one activation at a time, taken only from idle
  always_ff @(posedge clk) begin
    if (reset) begin
      state_r <= ite_pkg::ITE_IDLE;
      mem_req_r <= '0;
      mem_valid_r <= 1'b0;
      src_r <= 5'h00;
      vec_r <= 8'h00;
      ctl_r <= 8'h00;
      blk_r <= 8'h00;
      cnt_r <= 8'h00;
      rld_r <= 8'h00;
      sar_r <= 16'h0000;
      dar_r <= 16'h0000;
      left_r <= 9'h000;
      last_r <= 1'b0;
    end else begin
      case (state_r)
        ite_pkg::ITE_IDLE: begin
          if (ready != '0) begin
            src_r <= sel;
            mem_req_r <= '{addr: {ite_pkg::TOP_NIBBLE, base_r, 3'h0, sel},
                           we: 1'b0, wide: 1'b0, wdata: 16'h0000};
            mem_valid_r <= 1'b1;
            state_r <= ite_pkg::ITE_VEC;
          end
        end
        ite_pkg::ITE_VEC: if (mem_ack) begin
          vec_r <= mem_rdata[7:0];
          mem_req_r.addr <= {ite_pkg::TOP_NIBBLE, base_r, mem_rdata[7:0]};
          mem_req_r.wide <= 1'b1;
          state_r <= ite_pkg::ITE_D0;
        end
        ite_pkg::ITE_D0: if (mem_ack) begin
          ctl_r <= mem_rdata[7:0];
          blk_r <= mem_rdata[15:8];
          mem_req_r.addr <= {ite_pkg::TOP_NIBBLE, base_r, vec_r + ite_pkg::DESC_CNT};
          state_r <= ite_pkg::ITE_D1;
        end
        ite_pkg::ITE_D1: if (mem_ack) begin
          cnt_r <= mem_rdata[7:0];
          rld_r <= mem_rdata[15:8];
          mem_req_r.addr <= {ite_pkg::TOP_NIBBLE, base_r, vec_r + ite_pkg::DESC_SRC};
          state_r <= ite_pkg::ITE_D2;
        end
        ite_pkg::ITE_D2: if (mem_ack) begin
          sar_r <= mem_rdata;
          mem_req_r.addr <= {ite_pkg::TOP_NIBBLE, base_r, vec_r + ite_pkg::DESC_DST};
          state_r <= ite_pkg::ITE_D3;
        end
        ite_pkg::ITE_D3: if (mem_ack) begin
          dar_r <= mem_rdata;
          mem_valid_r <= 1'b0;
          left_r <= (blk_r == 8'h00) ? ite_pkg::FULL_BLOCK : {1'b0, blk_r};
          last_r <= (cnt_r == 8'h01);
          state_r <= ite_pkg::ITE_CHK;
        end
        ite_pkg::ITE_CHK: begin
          if (src_bad || dst_bad) begin
            state_r <= ite_pkg::ITE_IDLE;
          end else begin
            mem_req_r <= '{addr: src_a, we: 1'b0, wide: ctl_r[ite_pkg::CTL_WIDE],
                           wdata: 16'h0000};
            mem_valid_r <= 1'b1;
            state_r <= ite_pkg::ITE_RD;
          end
        end
        ite_pkg::ITE_RD: if (mem_ack) begin
          mem_req_r.addr <= dst_a;
          mem_req_r.we <= 1'b1;
          mem_req_r.wdata <= mem_rdata;
          state_r <= ite_pkg::ITE_WR;
        end
        ite_pkg::ITE_WR: if (mem_ack) begin
          left_r <= left_r - 9'h001;
          if (left_r == 9'h001) begin
            sar_r <= sar_nxt;
            dar_r <= dar_nxt;
            cnt_r <= cnt_nxt;
            mem_req_r <= '{addr: {ite_pkg::TOP_NIBBLE, base_r, vec_r + ite_pkg::DESC_CNT},
                           we: 1'b1, wide: 1'b1, wdata: {rld_r, cnt_nxt}};
            state_r <= ite_pkg::ITE_WB0;
          end else begin
            sar_r <= sinc ? sar_r + step : sar_r;
            dar_r <= dinc ? dar_r + step : dar_r;
            mem_req_r <= '{addr: {ite_pkg::TOP_NIBBLE, sinc ? sar_r + step : sar_r},
                           we: 1'b0, wide: ctl_r[ite_pkg::CTL_WIDE], wdata: 16'h0000};
            state_r <= ite_pkg::ITE_RD;
          end
        end
        ite_pkg::ITE_WB0: if (mem_ack) begin
          mem_req_r.addr <= {ite_pkg::TOP_NIBBLE, base_r, vec_r + ite_pkg::DESC_SRC};
          mem_req_r.wdata <= sar_r;
          state_r <= ite_pkg::ITE_WB1;
        end
        ite_pkg::ITE_WB1: if (mem_ack) begin
          mem_req_r.addr <= {ite_pkg::TOP_NIBBLE, base_r, vec_r + ite_pkg::DESC_DST};
          mem_req_r.wdata <= dar_r;
          state_r <= ite_pkg::ITE_WB2;
        end
        ite_pkg::ITE_WB2: if (mem_ack) begin
          mem_valid_r <= 1'b0;
          state_r <= ite_pkg::ITE_IDLE;
        end
        default: begin
          mem_valid_r <= 1'b0;
          state_r <= ite_pkg::ITE_IDLE;
        end
      endcase
    end
  end
endmodule // ite_engine

// File: verif/ite_checker.sv
// Port-level checks for the transfer engine
`timescale 1ns/1ps
module ite_checker #(
  parameter int SRC_NUM = 32,
  parameter logic [19:0] MIRROR_LO = 20'hF2000,
  parameter logic [19:0] MIRROR_HI = 20'hFEEFF
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic [SRC_NUM-1:0] cpu_irq,
  input wire logic cpu_bus_grant,
  input wire ite_pkg::ite_mem_req_t mem_req,
  input wire logic mem_valid,
  input wire logic mem_ack
);
  logic wb_done;
  logic [19:0] ad;
  assign wb_done = mem_valid && mem_ack && mem_req.we;
  assign ad = mem_req.addr;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("register access not answered in one cycle");
  a_bus_owner: assert property (!(cpu_bus_grant && mem_valid))
    else $error("processor granted while engine on bus");
  a_top_nibble: assert property (mem_valid |-> ad[19:16] == ite_pkg::TOP_NIBBLE)
    else $error("address outside top window");
  a_gpr_excl: assert property (mem_valid |-> !(ad >= ite_pkg::GPR_LO && ad <= ite_pkg::GPR_HI))
    else $error("general register area accessed");
  a_mirror_dst: assert property (mem_valid && mem_req.we |-> !(ad >= MIRROR_LO && ad <= MIRROR_HI))
    else $error("write into mirror area");
  a_req_hold: assert property (mem_valid && !mem_ack |=> mem_valid && $stable(mem_req))
    else $error("memory request changed before ack");
  a_irq_pulse: assert property (|cpu_irq |=> cpu_irq == '0 ##1 cpu_irq == '0)
    else $error("forwarded interrupt not a single pulse");
  a_irq_after_wb: assert property ($rose(|cpu_irq) |-> $past(wb_done) && $onehot(cpu_irq))
    else $error("interrupt without final writeback");
  c_irq: cover property (|cpu_irq);
  c_wb: cover property (wb_done);
  c_grant: cover property (cpu_bus_grant);
endmodule // ite_checker

// File: verif/ite_mem_model.sv
// Byte memory behind the engine's master port, optionally slow
`timescale 1ns/1ps
module ite_mem_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic slow,
  input wire ite_pkg::ite_mem_req_t mem_req,
  input wire logic mem_valid,
  output logic mem_ack,
  output logic [15:0] mem_rdata
);
  logic [7:0] mem [0:65535];
  logic [1:0] wait_r;
  logic go;
  logic [15:0] a;
  assign a = mem_req.addr[15:0];
  assign go = mem_valid && !mem_ack && (!slow || wait_r == 2'h3);
  always @(posedge clk) begin
    if (reset) begin
      mem_ack <= 1'b0;
      wait_r <= 2'h0;
      mem_rdata <= 16'h0;
    end else begin
      mem_ack <= go;
      wait_r <= (mem_valid && !mem_ack) ? wait_r + 2'h1 : 2'h0;
      // Outside an answer the data lines invert their last value every cycle
      mem_rdata <= go ? {mem_req.wide ? mem[a + 16'h1] : ~mem[a], mem[a]} : ~mem_rdata;
      if (mem_valid && mem_ack && mem_req.we) begin
        mem[a] <= mem_req.wdata[7:0];
        if (mem_req.wide) mem[a + 16'h1] <= mem_req.wdata[15:8];
      end
    end
  end
endmodule // ite_mem_model

// File: verif/ite_tb_top.sv
// Self-checking bench for the transfer engine
`timescale 1ns/1ps
module interrupt_triggered_transfer_engine_tb_top;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [2:0] avs_address = 3'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [31:0] src_irq = 32'h0;
  logic [31:0] cpu_irq;
  logic [31:0] last_irq = 32'h0;
  logic cpu_bus_grant;
  logic slow = 1'b0;
  logic cpu_bus_req = 1'b1;
  logic [3:0] avs_byteenable = 4'h1;
  ite_pkg::ite_mem_req_t mem_req;
  logic mem_valid;
  logic mem_ack;
  logic [15:0] mem_rdata;
  logic [31:0] q;
  logic [7:0] vecs [$];
  int fails = 0;
  int compares = 0;
  int irqs = 0;
  int acks = 0;
  always #2 clk = ~clk;
  ite_engine dut_u (.clk(clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .src_irq(src_irq),
    .cpu_irq(cpu_irq), .cpu_bus_req(cpu_bus_req), .cpu_bus_grant(cpu_bus_grant),
    .mem_req(mem_req),
    .mem_valid(mem_valid), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  ite_mem_model mem_u (.clk(clk), .reset(reset), .slow(slow), .mem_req(mem_req),
    .mem_valid(mem_valid), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  // Vector fetches land in the first 32 bytes of the base page
  always @(posedge clk) begin
    if (|cpu_irq) irqs <= irqs + 1;
    if (|cpu_irq) last_irq <= cpu_irq;
    if (mem_valid && mem_ack) acks <= acks + 1;
    if (mem_valid && mem_ack && !mem_req.we && mem_req.addr[15:5] == 11'h7D8) begin
      vecs.push_back(mem_req.addr[7:0]);
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic acc(input logic wr, input logic [2:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {24'h0, d};
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    // A wait limit that runs out counts as a mismatch
    if (avs_waitrequest !== 1'b0) fails++;
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic fire(input logic [31:0] m);
    @(posedge clk);
    src_irq <= m;
    @(posedge clk);
    src_irq <= 32'h0;
  endtask
  task automatic settle();
    int n;
    n = 0;
    repeat (3) @(posedge clk);
    do begin
      acc(1'b0, ite_pkg::REG_STATUS, 8'h0);
      n++;
    end while (q[ite_pkg::ST_BUSY] !== 1'b0 && n < 200);
    if (q[ite_pkg::ST_BUSY] !== 1'b0) fails++;
  endtask
  // Vector byte for source s, then the eight descriptor bytes at the vector's offset
  task automatic desc(input logic [7:0] s, v, c, b, n, r, input logic [15:0] sa, da);
    logic [63:0] d;
    d = {da, sa, r, n, b, c};
    mem_u.mem[{8'hFB, s}] = v;
    for (int k = 0; k < 8; k++) mem_u.mem[{8'hFB, v} + 16'(k)] = d[8*k +: 8];
  endtask
  task automatic t_regs();
    for (int i = 0; i < 6; i++) begin
      acc(1'b0, 3'(i), 8'h0);
      chk(q, 32'h0);
    end
    acc(1'b1, ite_pkg::REG_EN3, 8'hFF);
    acc(1'b0, ite_pkg::REG_EN3, 8'h0);
    chk(q, 32'hFF);
    acc(1'b1, ite_pkg::REG_EN3, 8'h00);
    acc(1'b1, 3'h6, 8'h5A);
    acc(1'b0, 3'h6, 8'h0);
    chk(q, 32'h0);
    acc(1'b1, ite_pkg::REG_BASE_PAGE, 8'hFB);
    acc(1'b0, ite_pkg::REG_BASE_PAGE, 8'h0);
    chk(q, 32'hFB);
  endtask
  task automatic t_normal();
    desc(8'h01, 8'h48, 8'h18, 8'h02, 8'h01, 8'h00, 16'h1000, 16'hFE00);
    mem_u.mem[16'h1000] = 8'hA5;
    mem_u.mem[16'h1001] = 8'h3C;
    slow <= 1'b1;
    acc(1'b1, ite_pkg::REG_EN0, 8'h02);
    fire(32'h2);
    settle();
    chk(vecs[0], 8'h01);
    chk(mem_u.mem[16'hFE00], 8'hA5);
    chk(mem_u.mem[16'hFE01], 8'h3C);
    chk(mem_u.mem[16'hFB4A], 8'h00);
    chk(mem_u.mem[16'hFB4C], 8'h02);
    chk(last_irq, 32'h2);
    acc(1'b0, ite_pkg::REG_EN0, 8'h0);
    chk(q, 32'h0);
  endtask
  task automatic t_repeat();
    desc(8'h09, 8'h50, 8'h12, 8'h01, 8'h01, 8'h01, 16'h1100, 16'hFE10);
    mem_u.mem[16'h1100] = 8'hC3;
    slow <= 1'b0;
    acc(1'b1, 3'h1, 8'h02);
    fire(32'h200);
    settle();
    chk(irqs, 1);
    chk(mem_u.mem[16'hFE10], 8'hC3);
    chk(mem_u.mem[16'hFB52], 8'h01);
    chk(mem_u.mem[16'hFB54], 8'h00);
    chk(mem_u.mem[16'hFB56], 8'h11);
    fire(32'h200);
    settle();
    chk(mem_u.mem[16'hFE11], 8'hC3);
    acc(1'b0, 3'h1, 8'h0);
    chk(q, 32'h2);
  endtask
  task automatic t_prio();
    vecs.delete();
    mem_u.mem[16'h1002] = 8'h5E;
    mem_u.mem[16'h1003] = 8'h6F;
    acc(1'b1, ite_pkg::REG_EN0, 8'h02);
    fire(32'h202);
    settle();
    settle();
    chk(vecs[0], 8'h01);
    chk(vecs[1], 8'h09);
    chk(mem_u.mem[16'hFE02], 8'h5E);
    chk(mem_u.mem[16'hFE03], 8'h6F);
    chk(mem_u.mem[16'hFB4A], 8'hFF);
  endtask
  // Wide repeat into a destination ring, a refused destination, a masked write, the grant
  task automatic t_wide_err();
    int n;
    desc(8'h02, 8'h58, 8'h2F, 8'h01, 8'h01, 8'h01, 16'h1200, 16'hFE20);
    mem_u.mem[16'h1200] = 8'h11;
    mem_u.mem[16'h1201] = 8'h22;
    acc(1'b1, ite_pkg::REG_EN0, 8'h04);
    fire(32'h4);
    settle();
    chk(mem_u.mem[16'hFE20], 8'h11);
    chk(mem_u.mem[16'hFE21], 8'h22);
    chk(mem_u.mem[16'hFB5C], 8'h02);
    chk(mem_u.mem[16'hFB5E], 8'h20);
    chk(last_irq, 32'h4);
    chk(irqs, 2);
    acc(1'b0, ite_pkg::REG_EN0, 8'h0);
    chk(q, 32'h0);
    desc(8'h03, 8'h60, 8'h00, 8'h01, 8'h01, 8'h00, 16'h1300, 16'h3000);
    mem_u.mem[16'h1300] = 8'h77;
    mem_u.mem[16'h3000] = 8'h5A;
    acc(1'b1, ite_pkg::REG_EN0, 8'h08);
    n = acks;
    fire(32'h8);
    settle();
    chk(acks - n, 5);
    chk(mem_u.mem[16'h3000], 8'h5A);
    chk(q, 32'h302);
    acc(1'b1, ite_pkg::REG_STATUS, 8'h02);
    acc(1'b0, ite_pkg::REG_STATUS, 8'h0);
    chk(q, 32'h300);
    avs_byteenable <= 4'h0;
    acc(1'b1, ite_pkg::REG_BASE_PAGE, 8'h12);
    avs_byteenable <= 4'h1;
    acc(1'b0, ite_pkg::REG_BASE_PAGE, 8'h0);
    chk(q, 32'hFB);
    chk(cpu_bus_grant, 1'b1);
    cpu_bus_req <= 1'b0;
    repeat (2) @(posedge clk);
    chk(cpu_bus_grant, 1'b0);
    cpu_bus_req <= 1'b1;
  endtask
  task automatic t_disable();
    int n;
    acc(1'b1, 3'h1, 8'h00);
    n = acks;
    fire(32'h200);
    repeat (10) @(posedge clk);
    chk(acks, n);
  endtask
  task automatic give_verdict();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    t_regs();
    t_normal();
    t_repeat();
    t_prio();
    t_wide_err();
    t_disable();
    give_verdict();
  end
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    give_verdict();
  end
endmodule // interrupt_triggered_transfer_engine_tb_top
bind ite_engine ite_checker #(.SRC_NUM(SRC_NUM), .MIRROR_LO(MIRROR_LO), .MIRROR_HI(MIRROR_HI))
  chk_u (.clk(clk), .reset(reset), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .cpu_irq(cpu_irq), .cpu_bus_grant(cpu_bus_grant),
  .mem_req(mem_req), .mem_valid(mem_valid), .mem_ack(mem_ack));
